// file: inc/ddr2_cmd_regs.svh
`ifndef DDR2_CMD_REGS_SVH
`define DDR2_CMD_REGS_SVH
// How it works
// R1: commands decoded from sampled cs ras cas we cke
// R2: chip select high accepts no new command
// R3: nop leaves ongoing operations undisturbed
// R4: load mode writes register chosen by bank
// R5: controller loads mode only when all idle
// R6: activate opens row until bank precharged
// R7: controller precharges before activating another row
// R8: read starts burst at column a9..a0
// R9: a10 on read precharges after burst
// R10: write burst, a10 precharges after burst
// R11: additive latency delays read and write internally
// R12: mask low stores data, high discards
// R13: precharge one or all, wait precharge time
// R14: other bank access allowed during auto precharge
// R15: controller activates idle bank before access
// R16: precharge idle bank restarts precharge timer
// R17: refresh all idle, internal row counter
// R18: refresh with cke low enters self refresh
// R19: dll off in self refresh, on after
// R20: termination covers data strobe mask lines
// R21: termination set by extended mode, odt input (code: enabled by the odt_cfg_en_in pin, no mode register is read)
// R22: no termination switching in self refresh
// R23: power down termination timing if latencies unmet (code: set only after PD_LAT_CYCLES cycles in power-down)
// R24: per bank open state and open row
`define NUM_BANKS      8
`define ROW_W          14
`define COL_W          10
`define AP_BIT         10
`define NUM_MODE_REGS  4
`define BURST_LEN      4
`define TRP_NS         15
`define CLK_PERIOD_NS  10
`define TRP_CYCLES     ((`TRP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRP_CNT_W      4
`define AL_MAX         7
`define AL_W           3
`define PD_LAT_CYCLES  3
`define MR_RESET       16'h0000
`endif

// file: inc/ddr2_cmd_pkg.sv
package ddr2_cmd_pkg;
  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_LMR, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
    CMD_REF, CMD_SREF, CMD_PDE, CMD_PDX, CMD_SRX, CMD_ILLEGAL
  } cmd_e;
  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_POWERDOWN, PWR_SELFREF
  } pwr_e;
endpackage

// file: src/ddr2_cmd_decode.sv
`include "ddr2_cmd_regs.svh"
module ddr2_cmd_decode (
  // command pins, sampled
  input  wire logic             cke_prev_in,
  input  wire logic             cke_in,
  input  wire logic             cs_n_in,
  input  wire logic             ras_n_in,
  input  wire logic             cas_n_in,
  input  wire logic             we_n_in,
  // decoded command
  output ddr2_cmd_pkg::cmd_e    cmd_out
);
  always_comb begin
    cmd_out = ddr2_cmd_pkg::CMD_ILLEGAL;
    if (cke_prev_in && !cke_in) begin
      if (cs_n_in || (ras_n_in && cas_n_in && we_n_in)) cmd_out = ddr2_cmd_pkg::CMD_PDE;
      else if (!ras_n_in && !cas_n_in && we_n_in) cmd_out = ddr2_cmd_pkg::CMD_SREF; // see R18
    end else if (!cke_prev_in && cke_in) begin
      if (cs_n_in || (ras_n_in && cas_n_in && we_n_in)) cmd_out = ddr2_cmd_pkg::CMD_PDX;
    end else if (!cke_prev_in) begin
      cmd_out = ddr2_cmd_pkg::CMD_NOP;
    end else if (cs_n_in) begin
      cmd_out = ddr2_cmd_pkg::CMD_DESEL; // see R2
    end else begin
      unique case ({ras_n_in, cas_n_in, we_n_in}) // see R1
        3'b111: cmd_out = ddr2_cmd_pkg::CMD_NOP; // see R3
        3'b000: cmd_out = ddr2_cmd_pkg::CMD_LMR;
        3'b011: cmd_out = ddr2_cmd_pkg::CMD_ACT;
        3'b101: cmd_out = ddr2_cmd_pkg::CMD_RD;
        3'b100: cmd_out = ddr2_cmd_pkg::CMD_WR;
        3'b010: cmd_out = ddr2_cmd_pkg::CMD_PRE;
        3'b001: cmd_out = ddr2_cmd_pkg::CMD_REF;
        3'b110: cmd_out = ddr2_cmd_pkg::CMD_ILLEGAL;
      endcase
    end
  end
endmodule

// file: src/ddr2_cmd_bank_odt.sv
`include "ddr2_cmd_regs.svh"
module ddr2_cmd_bank_odt (
  // clock, reset, enable
  input  wire logic                    core_clk_in,
  input  wire logic                    resetn_in,
  input  wire logic                    clk_en_in,
  // command pins
  input  wire logic                    cke_in,
  input  wire logic                    cs_n_in,
  input  wire logic                    ras_n_in,
  input  wire logic                    cas_n_in,
  input  wire logic                    we_n_in,
  input  wire logic [2:0]              ba_in,
  input  wire logic [`ROW_W-1:0]       addr_in,
  // write data mask and termination
  input  wire logic                    dm_in,
  input  wire logic                    wdata_valid_in,
  input  wire logic                    odt_in,
  // configuration
  input  wire logic [`AL_W-1:0]        additive_latency_in,
  input  wire logic                    odt_cfg_en_in,
  // array access
  output logic                         acc_valid_out,
  output logic                         acc_write_out,
  output logic [2:0]                   acc_bank_out,
  output logic [`ROW_W-1:0]            acc_row_out,
  output logic [`COL_W-1:0]            acc_col_out,
  output logic                         wr_store_out,
  output logic                         refresh_out,
  output logic [`ROW_W-1:0]            refresh_row_out,
  // state
  output logic [`NUM_BANKS-1:0]        bank_open_out,
  output logic [`NUM_BANKS-1:0]        bank_ready_out,
  output logic                         self_refresh_out,
  output logic                         power_down_out,
  output logic                         dll_on_out,
  output logic                         odt_active_out,
  output logic                         odt_pd_timing_out,
  output logic [15:0]                  mode_reg_out [`NUM_MODE_REGS]
);
  ddr2_cmd_pkg::cmd_e cmd;
  ddr2_cmd_pkg::pwr_e pwr_reg;
  logic                          cke_prev_reg;
  logic [`ROW_W-1:0]             open_row_reg [`NUM_BANKS];
  logic [`TRP_CNT_W-1:0]         trp_cnt_reg  [`NUM_BANKS];
  logic [`NUM_BANKS-1:0]         ap_pend_reg;
  logic [1:0]                    ap_cnt_reg   [`NUM_BANKS];
  // additive latency delay line
  logic [`AL_MAX:0]              dl_valid_reg;
  logic [`AL_MAX:0]              dl_write_reg;
  logic [`AL_MAX:0]              dl_ap_reg;
  logic [2:0]                    dl_bank_reg [`AL_MAX+1];
  logic [`COL_W-1:0]             dl_col_reg  [`AL_MAX+1];
  logic [2:0]                    wr_beats_reg;
  logic [2:0]                    pd_cnt_reg;
  logic                          issued_valid;
  logic                          issued_write;
  logic                          issued_ap;
  logic [2:0]                    issued_bank;
  logic [`COL_W-1:0]             issued_col;

  function automatic logic [`TRP_CNT_W-1:0] trp_load();
    return `TRP_CNT_W'(`TRP_CYCLES);
  endfunction

  // decoder compares cke with its value at the last edge
  ddr2_cmd_decode u_decode (
    .cke_prev_in (cke_prev_reg),
    .cke_in      (cke_in),
    .cs_n_in     (cs_n_in),
    .ras_n_in    (ras_n_in),
    .cas_n_in    (cas_n_in),
    .we_n_in     (we_n_in),
    .cmd_out     (cmd)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cke_prev_reg <= 1'b0;
    end else if (clk_en_in) begin
      cke_prev_reg <= cke_in;
    end
  end

  // power state and dll
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pwr_reg          <= ddr2_cmd_pkg::PWR_ACTIVE;
      self_refresh_out <= 1'b0;
      power_down_out   <= 1'b0;
      dll_on_out       <= 1'b1;
    end else if (clk_en_in) begin
      unique case (pwr_reg)
        ddr2_cmd_pkg::PWR_ACTIVE: begin
          if (cmd == ddr2_cmd_pkg::CMD_SREF) begin
            pwr_reg          <= ddr2_cmd_pkg::PWR_SELFREF;
            self_refresh_out <= 1'b1;
            dll_on_out       <= 1'b0; // see R19
          end else if (cmd == ddr2_cmd_pkg::CMD_PDE) begin
            pwr_reg        <= ddr2_cmd_pkg::PWR_POWERDOWN;
            power_down_out <= 1'b1;
          end
        end
        ddr2_cmd_pkg::PWR_POWERDOWN: begin
          if (cmd == ddr2_cmd_pkg::CMD_PDX) begin
            pwr_reg        <= ddr2_cmd_pkg::PWR_ACTIVE;
            power_down_out <= 1'b0;
          end
        end
        // exit shares the power-down exit decode
        ddr2_cmd_pkg::PWR_SELFREF: begin
          if (cmd == ddr2_cmd_pkg::CMD_PDX) begin
            pwr_reg          <= ddr2_cmd_pkg::PWR_ACTIVE;
            self_refresh_out <= 1'b0;
            dll_on_out       <= 1'b1; // see R19
          end
        end
        default: pwr_reg <= ddr2_cmd_pkg::PWR_ACTIVE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode registers; a bad load with banks open is the controller's fault
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < `NUM_MODE_REGS; i++) mode_reg_out[i] <= `MR_RESET;
    end else if (clk_en_in && cmd == ddr2_cmd_pkg::CMD_LMR) begin
      mode_reg_out[ba_in[1:0]] <= 16'(addr_in); // see R4 R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // additive latency: slot 0 is the issue point, commands enter at slot AL-1
  always_comb begin
    issued_valid = dl_valid_reg[0];
    issued_write = dl_write_reg[0];
    issued_ap    = dl_ap_reg[0];
    issued_bank  = dl_bank_reg[0];
    issued_col   = dl_col_reg[0];
    if (additive_latency_in == '0) begin
      issued_valid = (cmd == ddr2_cmd_pkg::CMD_RD) || (cmd == ddr2_cmd_pkg::CMD_WR);
      issued_write = (cmd == ddr2_cmd_pkg::CMD_WR);
      issued_ap    = addr_in[`AP_BIT];
      issued_bank  = ba_in;
      issued_col   = addr_in[`COL_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dl_valid_reg <= '0;
      dl_write_reg <= '0;
      dl_ap_reg    <= '0;
      for (int i = 0; i <= `AL_MAX; i++) begin
        dl_bank_reg[i] <= 3'h0;
        dl_col_reg[i]  <= '0;
      end
    end else if (clk_en_in) begin
      for (int i = 0; i < `AL_MAX; i++) begin
        dl_valid_reg[i] <= dl_valid_reg[i+1];
        dl_write_reg[i] <= dl_write_reg[i+1];
        dl_ap_reg[i]    <= dl_ap_reg[i+1];
        dl_bank_reg[i]  <= dl_bank_reg[i+1];
        dl_col_reg[i]   <= dl_col_reg[i+1];
      end
      dl_valid_reg[`AL_MAX] <= 1'b0;
      // a latency change to zero drops commands still in flight
      if (additive_latency_in != '0 &&
          (cmd == ddr2_cmd_pkg::CMD_RD || cmd == ddr2_cmd_pkg::CMD_WR)) begin // see R11
        dl_valid_reg[additive_latency_in-1'b1] <= 1'b1;
        dl_write_reg[additive_latency_in-1'b1] <= (cmd == ddr2_cmd_pkg::CMD_WR);
        dl_ap_reg[additive_latency_in-1'b1]    <= addr_in[`AP_BIT];
        dl_bank_reg[additive_latency_in-1'b1]  <= ba_in;
        dl_col_reg[additive_latency_in-1'b1]   <= addr_in[`COL_W-1:0];
      end
    end
  end

  // array access strobe
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_valid_out <= 1'b0;
      acc_write_out <= 1'b0;
      acc_bank_out  <= 3'h0;
      acc_row_out   <= '0;
      acc_col_out   <= '0;
    end else if (clk_en_in) begin
      acc_valid_out <= issued_valid; // see R8 R10 R14
      if (issued_valid) begin
        acc_write_out <= issued_write;
        acc_bank_out  <= issued_bank;
        acc_row_out   <= open_row_reg[issued_bank];
        acc_col_out   <= issued_col;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank state; tRP counts from the latest precharge to each bank
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bank_open_out  <= '0;
      bank_ready_out <= '1;
      ap_pend_reg    <= '0;
      for (int b = 0; b < `NUM_BANKS; b++) begin
        open_row_reg[b] <= '0;
        trp_cnt_reg[b]  <= '0;
        ap_cnt_reg[b]   <= 2'h0;
      end
    end else if (clk_en_in) begin
      for (int b = 0; b < `NUM_BANKS; b++) begin
        if (trp_cnt_reg[b] > 1) begin
          trp_cnt_reg[b] <= trp_cnt_reg[b] - 1'b1;
        end else if (trp_cnt_reg[b] == 1) begin
          trp_cnt_reg[b]    <= '0;
          bank_ready_out[b] <= 1'b1; // see R13
        end
        if (ap_pend_reg[b]) begin
          if (ap_cnt_reg[b] == 2'h0) begin
            ap_pend_reg[b]    <= 1'b0;
            bank_open_out[b]  <= 1'b0; // see R9 R10 R24
            bank_ready_out[b] <= 1'b0;
            trp_cnt_reg[b]    <= trp_load();
          end else begin
            ap_cnt_reg[b] <= ap_cnt_reg[b] - 1'b1;
          end
        end
        if (cmd == ddr2_cmd_pkg::CMD_PRE && (addr_in[`AP_BIT] || ba_in == 3'(b))) begin
          bank_open_out[b]  <= 1'b0; // see R13 R16
          bank_ready_out[b] <= 1'b0;
          ap_pend_reg[b]    <= 1'b0;
          trp_cnt_reg[b]    <= trp_load();
        end
      end
      if (issued_valid && issued_ap) begin
        ap_pend_reg[issued_bank] <= 1'b1;
        ap_cnt_reg[issued_bank]  <= 2'(`BURST_LEN / 2 - 1);
      end
      // refused inside tRP, but wins over an auto precharge closing the same bank in the same cycle
      if (cmd == ddr2_cmd_pkg::CMD_ACT &&
          bank_ready_out[ba_in]) begin
        bank_open_out[ba_in] <= 1'b1; // see R6 R13 R24
        open_row_reg[ba_in]  <= addr_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write mask: only unmasked beats reach the array
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_store_out <= 1'b0;
      wr_beats_reg <= 3'h0;
    end else if (clk_en_in) begin
      if (issued_valid && issued_write) begin
        wr_beats_reg <= 3'(`BURST_LEN);
      end else if (wdata_valid_in && wr_beats_reg != 3'h0) begin
        wr_beats_reg <= wr_beats_reg - 1'b1;
      end
      // a stray beat outside a burst must not hit a stale column
      wr_store_out <= wdata_valid_in && !dm_in &&
                      wr_beats_reg != 3'h0; // see R12
    end
  end

  // refresh with internal row counter; address pins ignored
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      refresh_out     <= 1'b0;
      refresh_row_out <= '0;
    end else if (clk_en_in) begin
      refresh_out <= (cmd == ddr2_cmd_pkg::CMD_REF); // see R17
      if (cmd == ddr2_cmd_pkg::CMD_REF || pwr_reg == ddr2_cmd_pkg::PWR_SELFREF) begin
        refresh_row_out <= refresh_row_out + 1'b1; // see R18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination; pd_cnt tracks whether power-down latencies are met
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      odt_active_out    <= 1'b0;
      odt_pd_timing_out <= 1'b0;
      pd_cnt_reg        <= 3'h0;
    end else if (clk_en_in) begin
      // covers dq, strobes and the single mask line with one enable
      odt_active_out <= odt_cfg_en_in && odt_in &&
                        pwr_reg != ddr2_cmd_pkg::PWR_SELFREF; // see R20 R21 R22
      // no exit latency kept: normal timing one cycle after exit
      if (pwr_reg == ddr2_cmd_pkg::PWR_POWERDOWN) begin
        if (pd_cnt_reg != 3'(`PD_LAT_CYCLES)) pd_cnt_reg <= pd_cnt_reg + 1'b1;
      end else begin
        pd_cnt_reg <= 3'h0;
      end
      odt_pd_timing_out <= pwr_reg == ddr2_cmd_pkg::PWR_POWERDOWN &&
                           pd_cnt_reg == 3'(`PD_LAT_CYCLES); // see R23
    end
  end
endmodule

// file: verification/ddr2_cmd_bank_odt_asserts.sv
`include "ddr2_cmd_regs.svh"
module ddr2_cmd_bank_odt_asserts (
  // clock, reset, enable
  input wire logic                core_clk_in,
  input wire logic                resetn_in,
  input wire logic                clk_en_in,
  // command and data pins
  input wire logic                cke_in,
  input wire logic                cs_n_in,
  input wire logic                ras_n_in,
  input wire logic                cas_n_in,
  input wire logic                we_n_in,
  input wire logic [2:0]          ba_in,
  input wire logic [`ROW_W-1:0]   addr_in,
  input wire logic                dm_in,
  input wire logic                wdata_valid_in,
  input wire logic                odt_in,
  input wire logic [`AL_W-1:0]    additive_latency_in,
  input wire logic                odt_cfg_en_in,
  // watched outputs
  input wire logic                acc_valid_out,
  input wire logic                acc_write_out,
  input wire logic [2:0]          acc_bank_out,
  input wire logic [`COL_W-1:0]   acc_col_out,
  input wire logic                wr_store_out,
  input wire logic                refresh_out,
  input wire logic [7:0]          bank_open_out,
  input wire logic [7:0]          bank_ready_out,
  input wire logic                self_refresh_out,
  input wire logic                dll_on_out,
  input wire logic                odt_active_out,
  input wire logic [15:0]         mode_reg_out [`NUM_MODE_REGS]
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////////////////////////////
  logic        cke_q;
  wire  [2:0]  rcw    = {ras_n_in, cas_n_in, we_n_in};
  wire         live   = clk_en_in && cke_q && cke_in && !cs_n_in;
  wire  [63:0] mr_all = {mode_reg_out[3], mode_reg_out[2], mode_reg_out[1], mode_reg_out[0]};
  // previous clock enable level, frozen along with the design
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) cke_q <= 1'b0;
    else if (clk_en_in) cke_q <= cke_in;
  end
  sequence closed_s;
    !bank_open_out[$past(ba_in)] && !bank_ready_out[$past(ba_in)];
  endsequence
  ////////////////////////////////////////////////////////////////
  act_open_a: assert property (live && rcw == 3'h3 && bank_ready_out[ba_in]
    |=> bank_open_out[$past(ba_in)]) else $error("activate did not open bank");
  act_refused_a: assert property (live && rcw == 3'h3 && !bank_ready_out[ba_in]
    |=> !bank_open_out[$past(ba_in)]) else $error("activate inside precharge time");
  pre_one_a: assert property (live && rcw == 3'h2 && !addr_in[`AP_BIT]
    |=> closed_s ##1 !bank_ready_out[$past(ba_in, 2)]) else $error("precharge timing wrong");
  pre_all_a: assert property (live && rcw == 3'h2 && addr_in[`AP_BIT]
    |=> bank_open_out == 8'h00) else $error("precharge all left a bank open");
  load_mode_a: assert property (live && rcw == 3'h0
    |=> mode_reg_out[$past(ba_in[1:0])][`ROW_W-1:0] == $past(addr_in)) else $error("mode load");
  desel_quiet_a: assert property (clk_en_in && cs_n_in && !self_refresh_out
    |=> $stable(mr_all) && !refresh_out) else $error("deselect acted");
  nop_quiet_a: assert property (live && rcw == 3'h7 |=> $stable(mr_all) && !refresh_out)
    else $error("nop acted");
  read_start_a: assert property (live && rcw == 3'h5 && additive_latency_in == 3'h0
    |=> acc_valid_out && !acc_write_out && acc_bank_out == $past(ba_in)
    && acc_col_out == $past(addr_in[`COL_W-1:0])) else $error("read access wrong");
  write_start_a: assert property (live && rcw == 3'h4 && additive_latency_in == 3'h0
    |=> acc_valid_out && acc_write_out && acc_col_out == $past(addr_in[`COL_W-1:0]))
    else $error("write access wrong");
  mask_store_a: assert property (clk_en_in && wdata_valid_in
    |=> wr_store_out == !$past(dm_in)) else $error("mask not honoured");
  refresh_go_a: assert property (live && rcw == 3'h1 |=> refresh_out)
    else $error("refresh not issued");
  self_ref_a: assert property (clk_en_in && cke_q && !cke_in && !cs_n_in && rcw == 3'h1
    |=> self_refresh_out && !dll_on_out) else $error("self refresh entry wrong");
  odt_sref_a: assert property (self_refresh_out [*2] |-> !odt_active_out)
    else $error("termination on in self refresh");
  odt_on_a: assert property (clk_en_in && cke_in && odt_cfg_en_in && odt_in
    && !self_refresh_out |=> odt_active_out) else $error("termination not switched on");
endmodule
bind ddr2_cmd_bank_odt ddr2_cmd_bank_odt_asserts i_ddr2_cmd_bank_odt_asserts (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in), .cke_in(cke_in),
  .cs_n_in(cs_n_in), .ras_n_in(ras_n_in), .cas_n_in(cas_n_in), .we_n_in(we_n_in),
  .ba_in(ba_in), .addr_in(addr_in), .dm_in(dm_in), .wdata_valid_in(wdata_valid_in),
  .odt_in(odt_in), .additive_latency_in(additive_latency_in), .odt_cfg_en_in(odt_cfg_en_in),
  .acc_valid_out(acc_valid_out), .acc_write_out(acc_write_out), .acc_bank_out(acc_bank_out),
  .acc_col_out(acc_col_out), .wr_store_out(wr_store_out), .refresh_out(refresh_out),
  .bank_open_out(bank_open_out), .bank_ready_out(bank_ready_out),
  .self_refresh_out(self_refresh_out), .dll_on_out(dll_on_out),
  .odt_active_out(odt_active_out), .mode_reg_out(mode_reg_out));

// file: verification/ddr2_ctrl_model.sv
`include "ddr2_cmd_regs.svh"
module ddr2_ctrl_model (
  // clock and bank status
  input  wire logic               clk_in,
  input  wire logic [7:0]         ready_in,
  // command pins
  output logic                    cke_out,
  output logic                    cs_n_out,
  output logic                    ras_n_out,
  output logic                    cas_n_out,
  output logic                    we_n_out,
  output logic [2:0]              ba_out,
  output logic [`ROW_W-1:0]       addr_out,
  // data qualifiers and termination
  output logic                    dm_out,
  output logic                    wdata_valid_out,
  output logic                    odt_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {cke_out, odt_out, dm_out, wdata_valid_out} = 4'h0;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
    ba_out = 3'h0;
    addr_out = 14'h0000;
  end
  task set_lv(input logic c, input logic o);
    cke_out = c;
    odt_out = o;
  endtask
  // idle cycles deselect with a command-like pattern and a toggling address
  task idle(input int n);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'h8;
    addr_out = ~addr_out;
    wdata_valid_out = 1'b0;
    dm_out = ~dm_out;
    repeat (n) begin
      @(posedge clk_in);
      #1;
    end
  endtask
  // the command stands until the next call replaces it
  task cmd(input logic [3:0] c, input logic [2:0] b, input logic [`ROW_W-1:0] a);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = c;
    ba_out = b;
    addr_out = a;
    @(posedge clk_in);
    #1;
  endtask
  // waits at most 8 idle cycles for the bank's precharge time to run out, then activates
  task act(input logic [2:0] b, input logic [`ROW_W-1:0] r);
    for (int i = 0; i < 8 && !ready_in[b]; i++) idle(1);
    cmd(4'h3, b, r);
  endtask
  task beat(input logic d);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'h8;
    wdata_valid_out = 1'b1;
    dm_out = d;
    @(posedge clk_in);
    #1;
  endtask
endmodule

// file: verification/ddr2_cmd_bank_odt_tb_top.sv
`include "ddr2_cmd_regs.svh"
module ddr2_cmd_bank_odt_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                core_clk_in, resetn_in, clk_en_in, odt_cfg_en_in, pd, pd_odt;
  logic                cke, cs_n, ras_n, cas_n, we_n, dm, wdv, odt;
  logic [2:0]          ba, al, acc_bank;
  logic [`ROW_W-1:0]   addr, acc_row, ref_row, old_row;
  logic [`COL_W-1:0]   acc_col;
  logic                acc_valid, acc_write, wr_store, refresh, self_ref, dll_on, odt_act;
  logic [7:0]          open, ready;
  logic [15:0]         mr [`NUM_MODE_REGS];
  int                  fail_count, n_checks, lat;
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  ddr2_cmd_bank_odt i_ddr2_cmd_bank_odt (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .clk_en_in(clk_en_in), .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n),
    .we_n_in(we_n), .ba_in(ba), .addr_in(addr), .dm_in(dm), .wdata_valid_in(wdv), .odt_in(odt),
    .additive_latency_in(al), .odt_cfg_en_in(odt_cfg_en_in), .acc_valid_out(acc_valid),
    .acc_write_out(acc_write), .acc_bank_out(acc_bank), .acc_row_out(acc_row),
    .acc_col_out(acc_col), .wr_store_out(wr_store), .refresh_out(refresh),
    .refresh_row_out(ref_row), .bank_open_out(open), .bank_ready_out(ready),
    .self_refresh_out(self_ref), .power_down_out(pd), .dll_on_out(dll_on),
    .odt_active_out(odt_act), .odt_pd_timing_out(pd_odt), .mode_reg_out(mr));
  ddr2_ctrl_model i_ddr2_ctrl_model (.clk_in(core_clk_in), .ready_in(ready), .cke_out(cke),
    .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba),
    .addr_out(addr), .dm_out(dm), .wdata_valid_out(wdv), .odt_out(odt));
  ////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for a bank to close after auto precharge
  task wait_closed(input int b);
    for (int i = 0; i < 10 && open[b] !== 1'b0; i++) i_ddr2_ctrl_model.idle(1);
  endtask
  initial begin
    #20000;
    fail_count++;
    finish_test;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {resetn_in, odt_cfg_en_in, al, clk_en_in} = 6'h01;
    repeat (10) @(posedge core_clk_in);
    #1 resetn_in = 1'b1;
    check("ready", ready, 8'hFF);
    check("dll", dll_on, 1'b1);
    i_ddr2_ctrl_model.set_lv(1'b1, 1'b0);
    i_ddr2_ctrl_model.idle(2);
    for (int i = 0; i < 4; i++) begin
      i_ddr2_ctrl_model.cmd(4'h0, 3'(i), 14'h01A0 + 14'(i));
      i_ddr2_ctrl_model.idle(2);
      check("mode reg", mr[i][13:0], 14'h01A0 + 14'(i));
    end
    i_ddr2_ctrl_model.cmd(4'h8, 3'h0, 14'h3FFF);
    check("deselect", mr[0], 16'h01A0);
    i_ddr2_ctrl_model.cmd(4'h7, 3'h0, 14'h3FFF);
    check("nop", mr[0], 16'h01A0);
    i_ddr2_ctrl_model.act(3'h2, 14'h0022);
    i_ddr2_ctrl_model.act(3'h1, 14'h0005);
    check("act", open[1], 1'b1);
    i_ddr2_ctrl_model.cmd(4'h5, 3'h1, 14'h0403);
    check("rd", {acc_valid, acc_write, acc_bank, acc_row, acc_col}, {2'h2, 3'h1, 14'h5, 10'h3});
    i_ddr2_ctrl_model.cmd(4'h5, 3'h2, 14'h0007);
    check("rd other", {acc_bank, acc_row, acc_col}, {3'h2, 14'h22, 10'h7});
    wait_closed(1);
    check("ap close", {open[1], ready[1], open[2]}, 3'h1);
    i_ddr2_ctrl_model.cmd(4'h4, 3'h2, 14'h0010);
    check("wr", {acc_valid, acc_write, acc_col}, {2'h3, 10'h10});
    for (int i = 0; i < 4; i++) begin
      i_ddr2_ctrl_model.beat(i[0]);
      check("store", wr_store, !i[0]);
    end
    i_ddr2_ctrl_model.idle(1);
    check("no ap", open[2], 1'b1);
    i_ddr2_ctrl_model.cmd(4'h4, 3'h2, 14'h0410);
    wait_closed(2);
    check("wr ap", open[2], 1'b0);
    i_ddr2_ctrl_model.act(3'h3, 14'h0033);
    for (int i = 0; i < 4; i++) begin
      al = 3'(i);
      i_ddr2_ctrl_model.cmd(4'h5, 3'h3, 14'(i));
      for (lat = 1; lat < 12 && acc_valid !== 1'b1; lat++) i_ddr2_ctrl_model.idle(1);
      check("latency", lat, i + 1);
      i_ddr2_ctrl_model.idle(4);
    end
    al = 3'h0;
    i_ddr2_ctrl_model.cmd(4'h2, 3'h3, 14'h0000);
    check("pre", {open[3], ready[3]}, 2'h0);
    i_ddr2_ctrl_model.cmd(4'h2, 3'h3, 14'h0000);
    i_ddr2_ctrl_model.cmd(4'h3, 3'h3, 14'h0033);
    check("restart", {open[3], ready[3]}, 2'h0);
    i_ddr2_ctrl_model.idle(1);
    check("trp", ready[3], 1'b1);
    i_ddr2_ctrl_model.act(3'h4, 14'h0044);
    i_ddr2_ctrl_model.act(3'h5, 14'h0055);
    i_ddr2_ctrl_model.cmd(4'h2, 3'h0, 14'h0400);
    check("pre all", open, 8'h00);
    i_ddr2_ctrl_model.idle(3);
    old_row = ref_row;
    i_ddr2_ctrl_model.cmd(4'h1, 3'h0, 14'h2AAA);
    check("refresh", refresh, 1'b1);
    i_ddr2_ctrl_model.idle(1);
    check("ref row", ref_row, old_row + 14'h1);
    odt_cfg_en_in = 1'b1;
    i_ddr2_ctrl_model.set_lv(1'b1, 1'b1);
    i_ddr2_ctrl_model.idle(2);
    check("odt on", odt_act, 1'b1);
    i_ddr2_ctrl_model.set_lv(1'b0, 1'b1);
    i_ddr2_ctrl_model.cmd(4'h1, 3'h0, 14'h0000);
    check("sref", {self_ref, dll_on}, 2'h2);
    i_ddr2_ctrl_model.idle(2);
    check("odt sref", odt_act, 1'b0);
    i_ddr2_ctrl_model.set_lv(1'b1, 1'b0);
    i_ddr2_ctrl_model.idle(4);
    check("sref exit", {self_ref, dll_on}, 2'h1);
    i_ddr2_ctrl_model.set_lv(1'b0, 1'b1);
    i_ddr2_ctrl_model.idle(3);
    check("pd early", {pd, pd_odt, odt_act}, 3'h5);
    i_ddr2_ctrl_model.idle(2);
    check("pd late", {pd, pd_odt}, 2'h3);
    i_ddr2_ctrl_model.set_lv(1'b1, 1'b0);
    i_ddr2_ctrl_model.idle(2);
    check("pd exit", {pd, pd_odt}, 2'h0);
    clk_en_in = 1'b0;
    i_ddr2_ctrl_model.act(3'h6, 14'h0001);
    check("frozen", open[6], 1'b0);
    clk_en_in = 1'b1;
    i_ddr2_ctrl_model.idle(2);
    finish_test;
  end
endmodule
